// ### design/pfcp_defines.svh
// Timing counts for the power-factor pulse and protection logic
`ifndef PFCP_DEFINES_SVH
`define PFCP_DEFINES_SVH
`define PFCP_CLK_MHZ 250
`define PFCP_MIN_OFF_NS 600
`define PFCP_MIN_OFF_CYC ((`PFCP_MIN_OFF_NS * `PFCP_CLK_MHZ + 999) / 1000)
`define PFCP_PCL_GLITCH_NS 200
`define PFCP_PCL_GLITCH_CYC ((`PFCP_PCL_GLITCH_NS * `PFCP_CLK_MHZ + 999) / 1000)
`define PFCP_SECOND_OVERVOLT_FAULT_US 12
`define PFCP_SECOND_OVERVOLT_FAULT_CYC (`PFCP_SECOND_OVERVOLT_FAULT_US * `PFCP_CLK_MHZ)
`define PFCP_BROWN_US 20
`define PFCP_BROWN_CYC (`PFCP_BROWN_US * `PFCP_CLK_MHZ)
`define PFCP_OLP_US 1
`define PFCP_OLP_CYC (`PFCP_OLP_US * `PFCP_CLK_MHZ)
`define PFCP_SW_KHZ 65
`define PFCP_PERIOD_CYC (`PFCP_CLK_MHZ * 1000 / `PFCP_SW_KHZ)
`define PFCP_DUTY_CEILING_PCT 95
`define PFCP_MAX_ON_CYC (`PFCP_PERIOD_CYC * `PFCP_DUTY_CEILING_PCT / 100)
`define PFCP_ADDR_CTRL 32'h0000_0000
`define PFCP_ADDR_STAT 32'h0000_0004
`define PFCP_CTRL_RST 32'h0000_0000
`endif

// ### design/pfcp_pkg.sv
// Types for the power-factor pulse and protection logic
package pfcp_pkg;
  typedef enum logic [1:0] {
    PFCP_OFF = 2'b00,
    PFCP_MINOFF = 2'b01,
    PFCP_RAMP = 2'b10,
    PFCP_ON = 2'b11
  } pfcp_phase_e;
  typedef enum logic [1:0] {
    PFCP_RUN_STOP = 2'b00,
    PFCP_RUN_SOFT = 2'b01,
    PFCP_RUN_NORM = 2'b10,
    PFCP_RUN_LATCH = 2'b11
  } pfcp_run_e;
  // Comparator results from the analog front end, all active high
  typedef struct packed {
    logic ramp_cross;
    logic peak_trip;
    logic line_above_125;
    logic line_above_100;
    logic line_below_230;
    logic fb_below_050;
    logic fb_above_270;
    logic fb_below_rated;
    logic fb_above_095;
    logic fb_below_bgthr;
    logic second_overvolt_fault_above_250;
    logic second_overvolt_fault_below_230;
    logic thr_below_050;
    logic thr_high_load;
    logic load_below_050;
  } pfcp_cmp_s;
  typedef struct packed {
    logic gate;
    logic ramp_release;
    logic bulk_good_out;
    logic follower_on;
    logic hyst_res_on;
  } pfcp_out_s;
endpackage

// ### design/pfcp_top.sv
// Gate, fault sequencing and status slave of the power-factor controller
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
`include "pfcp_defines.svh"

module pfcp_top #(
  parameter int SECOND_OVERVOLT_FAULT_CYC = `PFCP_SECOND_OVERVOLT_FAULT_CYC,
  parameter int BROWN_CYC = `PFCP_BROWN_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Supply lockout, high while supply is below threshold
  input wire logic supply_lockout_i,
  // Comparator results
  input wire pfcp_pkg::pfcp_cmp_s cmp_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Analog controls
  output pfcp_pkg::pfcp_out_s out_o
);
  import pfcp_pkg::*;

  localparam int MINOFF = `PFCP_MIN_OFF_CYC;
  localparam int GLITCH = `PFCP_PCL_GLITCH_CYC;
  localparam int OPEN_LOOP_FAULT = `PFCP_OLP_CYC;
  localparam int PERIOD = `PFCP_PERIOD_CYC;
  localparam int MAXON = `PFCP_MAX_ON_CYC;

  pfcp_cmp_s sync1_reg;
  pfcp_cmp_s cmp_reg;
  logic lock1_reg;
  logic lock_reg;

  // Two stage synchroniser; first stage feeds only the second
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1_reg <= '0;
      cmp_reg <= '0;
      lock1_reg <= 1'b1;
      lock_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= cmp_i;
      cmp_reg <= sync1_reg;
      lock1_reg <= supply_lockout_i;
      lock_reg <= lock1_reg;
    end
  end

  // Peak deglitch
  logic [7:0] glitch_reg;
  logic peak_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cmp_reg.peak_trip)
    begin
      glitch_reg <= 8'h00;
      peak_reg <= 1'b0;
    end
    else if (glitch_reg < 8'(GLITCH - 1))
      glitch_reg <= glitch_reg + 8'h01;
    else
      peak_reg <= 1'b1;
  end

  // Persistence counters
  logic [15:0] brown_cnt_reg;
  logic [15:0] olp_cnt_reg;
  logic [15:0] second_overvolt_fault_cnt_reg;
  logic brown_reg;
  logic olp_reg;
  logic second_overvolt_fault_reg;
  logic first_overvolt_fault_reg;
  logic mode_latch_reg;
  logic mode_seen_reg;
  pfcp_run_e run_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || cmp_reg.line_above_100)
      brown_cnt_reg <= 16'h0000;
    else if (brown_cnt_reg < 16'(BROWN_CYC))
      brown_cnt_reg <= brown_cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cmp_reg.fb_below_050)
      olp_cnt_reg <= 16'h0000;
    else if (olp_cnt_reg < 16'(OPEN_LOOP_FAULT))
      olp_cnt_reg <= olp_cnt_reg + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cmp_reg.second_overvolt_fault_above_250)
      second_overvolt_fault_cnt_reg <= 16'h0000;
    else if (second_overvolt_fault_cnt_reg < 16'(SECOND_OVERVOLT_FAULT_CYC))
      second_overvolt_fault_cnt_reg <= second_overvolt_fault_cnt_reg + 16'h0001;
  end

  // Fault flags; all but the open-loop flag release with hysteresis
  always_ff @(posedge clk_i)
  begin
    if (rst_i || lock_reg)
    begin
      brown_reg <= 1'b1;
      olp_reg <= 1'b1;
      second_overvolt_fault_reg <= 1'b0;
      first_overvolt_fault_reg <= 1'b0;
    end
    else
    begin
      if (brown_cnt_reg == 16'(BROWN_CYC))
        brown_reg <= 1'b1;
      else if (cmp_reg.line_above_125)
        brown_reg <= 1'b0;
      if (olp_cnt_reg == 16'(OPEN_LOOP_FAULT))
        olp_reg <= 1'b1;
      else if (!cmp_reg.fb_below_050)
        olp_reg <= 1'b0;
      // Held until its own window is exited
      if (cmp_reg.second_overvolt_fault_above_250)
        second_overvolt_fault_reg <= 1'b1;
      else if (cmp_reg.second_overvolt_fault_below_230)
        second_overvolt_fault_reg <= 1'b0;
      if (cmp_reg.fb_above_270)
        first_overvolt_fault_reg <= 1'b1;
      else if (cmp_reg.fb_below_rated)
        first_overvolt_fault_reg <= 1'b0;
    end
  end

  // Mode strap caught once after lockout release
  always_ff @(posedge clk_i)
  begin
    if (rst_i || lock_reg)
    begin
      mode_seen_reg <= 1'b0;
      mode_latch_reg <= 1'b0;
    end
    else if (!mode_seen_reg)
    begin
      mode_seen_reg <= 1'b1;
      mode_latch_reg <= cmp_reg.thr_high_load;
    end
  end

  logic stop_cond;
  logic second_overvolt_fault_long;
  assign second_overvolt_fault_long = second_overvolt_fault_cnt_reg == 16'(SECOND_OVERVOLT_FAULT_CYC);
  assign stop_cond = brown_reg || olp_reg || cmp_reg.thr_below_050 ||
                     !mode_seen_reg;

  // Run sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i || lock_reg)
      run_reg <= PFCP_RUN_STOP;
    else
    begin
      case (run_reg)
        PFCP_RUN_LATCH: run_reg <= PFCP_RUN_LATCH;
        default:
        begin
          if (second_overvolt_fault_long && mode_latch_reg)
            run_reg <= PFCP_RUN_LATCH;
          else if (stop_cond || (second_overvolt_fault_long && second_overvolt_fault_reg))
            run_reg <= PFCP_RUN_STOP;
          else if (run_reg == PFCP_RUN_STOP)
            run_reg <= PFCP_RUN_SOFT;
          else if (run_reg == PFCP_RUN_SOFT && cmp_reg.fb_above_095)
            run_reg <= PFCP_RUN_NORM;
        end
      endcase
    end
  end

  logic running;
  logic gate_block;
  assign running = run_reg == PFCP_RUN_SOFT || run_reg == PFCP_RUN_NORM;
  // Either stage alone blocks the gate
  assign gate_block = !running || first_overvolt_fault_reg || second_overvolt_fault_reg ||
                      cmp_reg.second_overvolt_fault_above_250 || lock_reg;

  // Pulse-width cycle
  pfcp_phase_e phase_reg;
  logic [15:0] period_reg;
  logic [15:0] off_cnt_reg;
  logic limit_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      period_reg <= 16'h0000;
    else if (period_reg == 16'(PERIOD - 1))
      period_reg <= 16'h0000;
    else
      period_reg <= period_reg + 16'h0001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || period_reg == 16'(PERIOD - 1))
    begin
      phase_reg <= PFCP_MINOFF;
      off_cnt_reg <= 16'h0000;
      limit_reg <= 1'b0;
    end
    else
    begin
      if (peak_reg)
        limit_reg <= 1'b1;
      case (phase_reg)
        PFCP_MINOFF:
        begin
          off_cnt_reg <= off_cnt_reg + 16'h0001;
          if (off_cnt_reg == 16'(MINOFF - 1))
            phase_reg <= PFCP_RAMP;
        end
        PFCP_RAMP:
          if (cmp_reg.ramp_cross)
            phase_reg <= PFCP_ON;
        PFCP_ON:
          if (period_reg >= 16'(MAXON - 1))
            phase_reg <= PFCP_OFF;
        PFCP_OFF: phase_reg <= PFCP_OFF;
        default: phase_reg <= PFCP_OFF;
      endcase
    end
  end

  logic bulk_good_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !running)
      bulk_good_reg <= 1'b0;
    else if (run_reg == PFCP_RUN_SOFT && cmp_reg.fb_above_095)
      bulk_good_reg <= 1'b1;
    else if (cmp_reg.fb_below_bgthr)
      bulk_good_reg <= 1'b0;
  end

  logic follow_next;
  assign follow_next = run_reg == PFCP_RUN_NORM && cmp_reg.line_below_230 &&
                       cmp_reg.load_below_050;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_o <= '0;
    else
    begin
      // Gate only in on phase without limit
      out_o.gate <= phase_reg == PFCP_ON && !limit_reg && !peak_reg &&
                    !gate_block && period_reg != 16'(PERIOD - 1);
      out_o.ramp_release <= phase_reg == PFCP_RAMP;
      out_o.bulk_good_out <= bulk_good_reg;
      out_o.follower_on <= follow_next;
      out_o.hyst_res_on <= follow_next;
    end
  end

  // Wishbone: control word and live status, ack one cycle after request
  logic [31:0] ctrl_reg;
  logic hit_ctrl;
  logic hit_stat;
  assign hit_ctrl = wb_adr_i == `PFCP_ADDR_CTRL;
  assign hit_stat = wb_adr_i == `PFCP_ADDR_STAT;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_reg <= `PFCP_CTRL_RST;
    // Write lands on the edge where the master sees ack, not before
    else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && hit_ctrl)
    begin
      for (int i = 0; i < 4; i++)
        if (wb_sel_i[i])
          ctrl_reg[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (hit_ctrl)
      wb_dat_o <= ctrl_reg;
    else if (hit_stat)
      wb_dat_o <= {20'h00000, mode_latch_reg, first_overvolt_fault_reg, second_overvolt_fault_reg,
                   olp_reg, brown_reg, limit_reg, phase_reg,
                   run_reg, bulk_good_reg, lock_reg};
    else
      wb_dat_o <= 32'h0000_0000;
  end

  p_gate_lock: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_reg |=> !out_o.gate)
    else $error("gate high under lockout");
  p_minoff_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (period_reg == 16'h0000) |-> ##1 !out_o.gate [*8])
    else $error("gate during minimum off");
  p_ramp_late: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(phase_reg == PFCP_RAMP) |-> off_cnt_reg == 16'(MINOFF))
    else $error("ramp released early");
  p_peak_off: assert property (@(posedge clk_i) disable iff (rst_i)
    peak_reg |=> !out_o.gate)
    else $error("gate on after peak trip");
  p_glitch: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(peak_reg) |-> $past(cmp_reg.peak_trip, 50))
    else $error("deglitch too short");
  p_second_overvolt_fault_off: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_reg.second_overvolt_fault_above_250 |=> !out_o.gate)
    else $error("gate on during second overvoltage");
  p_follow_soft: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_reg == PFCP_RUN_SOFT) |=> !out_o.follower_on)
    else $error("follower during soft-start");
  p_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (run_reg == PFCP_RUN_LATCH && !lock_reg) |=> run_reg == PFCP_RUN_LATCH)
    else $error("latched fault released");
  p_duty: assert property (@(posedge clk_i) disable iff (rst_i)
    out_o.gate |-> period_reg <= 16'(MAXON + 1))
    else $error("duty ceiling exceeded");
endmodule

// ### dv/pfcp_afe_model.sv
// Ramp comparator model of the analog front end
`timescale 1ns/1ps
module pfcp_afe_model #(
  parameter int RAMP_CYC = 1000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Ramp control from the block, levels from the bench
  input wire logic ramp_release_i,
  input wire pfcp_pkg::pfcp_cmp_s lvl_i,
  // Comparator results to the block
  output pfcp_pkg::pfcp_cmp_s cmp_o
);
  import pfcp_pkg::*;
  int ramp_reg;
  // Ramp is discharged while release is low, so the crossing drops on the next clock edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !ramp_release_i)
      ramp_reg <= 0;
    else if (ramp_reg < RAMP_CYC)
      ramp_reg <= ramp_reg + 1;
  end
  always_comb
  begin
    cmp_o = lvl_i;
    cmp_o.ramp_cross = (ramp_reg >= RAMP_CYC);
  end
endmodule

// ### dv/tb.sv
// Self-checking bench for the pulse and protection logic
`timescale 1ns/1ps
`include "pfcp_defines.svh"
module tb;
  import pfcp_pkg::*;
  localparam int RAMP = 1000;
  localparam int OFF0 = `PFCP_PERIOD_CYC - `PFCP_MAX_ON_CYC
    + `PFCP_MIN_OFF_CYC;
  localparam int G = 4;
  localparam int BG = 2;
  localparam int FO = 1;
  logic clk_i;
  logic rst_i;
  logic lock;
  pfcp_cmp_s lvl;
  pfcp_cmp_s cmp;
  logic cyc;
  logic stb;
  logic we;
  logic [31:0] adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic ack;
  pfcp_out_s out;
  logic [31:0] q;
  int n_errors;
  int samples_checked;

  pfcp_top #(.SECOND_OVERVOLT_FAULT_CYC(20), .BROWN_CYC(30)) i_pfcp_top (
    .clk_i(clk_i), .rst_i(rst_i), .supply_lockout_i(lock), .cmp_i(cmp),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .out_o(out));
  pfcp_afe_model #(.RAMP_CYC(RAMP)) i_pfcp_afe_model (
    .clk_i(clk_i), .rst_i(rst_i), .ramp_release_i(out.ramp_release),
    .lvl_i(lvl), .cmp_o(cmp));

  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic give_up();
    n_errors++;
    $display("unexpected wait expired");
    print_verdict();
  endtask

  task automatic wb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
      give_up();
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_out(input int b, input logic v, input int lim,
                          output int n);
    n = 0;
    while (out[b] !== v && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
    if (out[b] !== v)
      give_up();
  endtask

  task automatic t_regs();
    wb(1'b0, `PFCP_ADDR_CTRL, 32'h0);
    chk("ctrl reset", q, `PFCP_CTRL_RST);
    wb(1'b1, `PFCP_ADDR_CTRL, 32'ha5c3_0f96);
    wb(1'b0, `PFCP_ADDR_CTRL, 32'h0);
    chk("ctrl rw", q, 32'ha5c3_0f96);
    wb(1'b1, 32'h0000_0040, 32'hffff_ffff);
    wb(1'b0, 32'h0000_0040, 32'h0);
    chk("unmapped", q, 32'h0);
    wb(1'b0, `PFCP_ADDR_STAT, 32'h0);
    chk("lock bit", q[0], 1'b1);
  endtask

  task automatic t_pulse();
    int n;
    int k;
    int r;
    lock <= 1'b0;
    wait_out(G, 1'b1, 9000, n);
    chk("follower soft", out.follower_on, 1'b0);
    wait_out(G, 1'b0, 4000, n);
    chk("on cap", n <= `PFCP_MAX_ON_CYC, 1'b1);
    k = 0;
    r = 0;
    while (out.gate === 1'b0 && k < 5000)
    begin
      if (r == 0 && out.ramp_release === 1'b1)
        r = k;
      @(posedge clk_i);
      k++;
    end
    chk("release", r >= OFF0 - 4 && r <= OFF0 + 6, 1'b1);
    chk("cross", k - r >= RAMP && k - r <= RAMP + 8, 1'b1);
    chk("period", n + k, `PFCP_PERIOD_CYC);
  endtask

  task automatic t_peak();
    int n;
    lvl.peak_trip <= 1'b1;
    repeat (30) @(posedge clk_i);
    lvl.peak_trip <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("glitch", out.gate, 1'b1);
    lvl.peak_trip <= 1'b1;
    wait_out(G, 1'b0, 60, n);
    chk("trip delay", n >= 50, 1'b1);
    lvl.peak_trip <= 1'b0;
    repeat (300) @(posedge clk_i);
    chk("held off", out.gate, 1'b0);
  endtask

  task automatic t_ovp();
    int n;
    wait_out(G, 1'b1, 9000, n);
    lvl.fb_above_270 <= 1'b1;
    lvl.fb_below_rated <= 1'b0;
    wait_out(G, 1'b0, 8, n);
    lvl.second_overvolt_fault_above_250 <= 1'b1;
    lvl.second_overvolt_fault_below_230 <= 1'b0;
    repeat (100) @(posedge clk_i);
    lvl.second_overvolt_fault_above_250 <= 1'b0;
    lvl.second_overvolt_fault_below_230 <= 1'b1;
    lvl.fb_above_270 <= 1'b0;
    repeat (8000) @(posedge clk_i);
    chk("both windows", out.gate, 1'b0);
    lvl.fb_below_rated <= 1'b1;
    wait_out(G, 1'b1, 9000, n);
  endtask

  task automatic t_latch();
    int n;
    lock <= 1'b1;
    lvl.thr_high_load <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("gate lockout", out.gate, 1'b0);
    lock <= 1'b0;
    wait_out(G, 1'b1, 9000, n);
    lvl.thr_high_load <= 1'b0;
    lvl.second_overvolt_fault_above_250 <= 1'b1;
    lvl.second_overvolt_fault_below_230 <= 1'b0;
    wait_out(G, 1'b0, 8, n);
    repeat (100) @(posedge clk_i);
    lvl.second_overvolt_fault_above_250 <= 1'b0;
    lvl.second_overvolt_fault_below_230 <= 1'b1;
    repeat (8000) @(posedge clk_i);
    chk("latched", out.gate, 1'b0);
    lock <= 1'b1;
    repeat (10) @(posedge clk_i);
    lock <= 1'b0;
    wait_out(G, 1'b1, 9000, n);
  endtask

  task automatic t_bulk();
    int n;
    lvl.fb_above_095 <= 1'b1;
    wait_out(BG, 1'b1, 10, n);
    wait_out(FO, 1'b1, 10, n);
    chk("res on", out.hyst_res_on, 1'b1);
    lvl.load_below_050 <= 1'b0;
    wait_out(FO, 1'b0, 10, n);
    chk("res off", out.hyst_res_on, 1'b0);
    lvl.line_below_230 <= 1'b0;
    lvl.load_below_050 <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk("high line", out.follower_on, 1'b0);
    lvl.fb_below_bgthr <= 1'b1;
    wait_out(BG, 1'b0, 10, n);
    lvl.fb_below_bgthr <= 1'b0;
  endtask

  // Brown-out and open-loop faults are timed against the run field so short dips must not stop it; a thr_below_050 dip stops it within 10 cycles
  task automatic t_trip(input logic [14:0] m, input int hold,
                        input logic [1:0] r);
    int n;
    n = 0;
    do
    begin
      repeat (100) @(posedge clk_i);
      wb(1'b0, `PFCP_ADDR_STAT, 32'h0);
      n++;
    end
    while (q[3:2] !== 2'h2 && n < 100);
    if (q[3:2] !== 2'h2)
      give_up();
    lvl <= pfcp_cmp_s'(lvl ^ m);
    repeat (hold) @(posedge clk_i);
    wb(1'b0, `PFCP_ADDR_STAT, 32'h0);
    chk("run", q[3:2], r);
    lvl <= pfcp_cmp_s'(lvl ^ m);
  endtask

  initial
  begin
    int n;
    rst_i = 1'b1;
    lock = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 32'h0;
    wdat = 32'h0;
    lvl = 15'h1c89;
    n_errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_i);
    chk("reset out", out, 5'h0);
    rst_i <= 1'b0;
    t_regs();
    t_pulse();
    t_peak();
    t_ovp();
    t_latch();
    t_bulk();
    t_trip(15'h1800, 20, 2'h2);
    t_trip(15'h1800, 60, 2'h0);
    t_trip(15'h0200, 200, 2'h2);
    t_trip(15'h0200, 300, 2'h0);
    t_trip(15'h0004, 10, 2'h0);
    wait_out(G, 1'b1, 9000, n);
    print_verdict();
  end
endmodule
